// ---- logic/ram_fifo_block.sv ----
// Purpose: Embedded memory block working as dual-port RAM or FIFO
// Assumes: Side clocks and strobes are sampled on clk_i, which runs much faster
// Notes: Pointer reset clears pointers and output, never the storage
`timescale 1ns/1ps
`include "fifo_block_defines.svh"

// Notes on behaviour
// R1 - Writes are dropped while the FIFO is full.
// R2 - Reads are dropped while empty; read pointer holds.
// R3 - Pointer reset: empty set, counters cleared, output zero, storage kept.
// R4 - Partner must not count on acceptance 1 to 3 ns after a flag-ending strobe.
// R5 - Read and write to one location together return the write data.
// R6 - During an asynchronous read, a write to that location refreshes the output.
// R7 - Level-equal on exact match, level-at-least on match or above.
// R8 - Deep FIFO: threshold is doubled level, equal flag at threshold plus one.
// R9 - Depth is two to the power of depth select plus one.
// R10 - Odd select high gives odd parity, low gives even.
// R11 - Parity generation replaces data bit 8 with a computed bit.
// R12 - Separate active-high read and write parity error outputs.
// R13 - Partner ignores write parity error while generation is enabled.
// R14 - Read strobe, read select, write strobe, write select are active low.
// R15 - Synchronous write captures data, address, strobe, select on write clock rise.
// R16 - Pipelined read samples strobe on read clock rise, new data follows it.
// R17 - Flags update on read clock fall and are invalid until then.
// R18 - Pointers wrap modulo depth; a count keeps full and empty apart.
module ram_fifo_block #(
    parameter int ADDR_W = 9
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Configuration
    input wire logic fifo_mode_i,
    input wire logic [`DSEL_W-1:0] depth_log_select_i,
    input wire logic [`LEVEL_W-1:0] level_i,
    input wire logic odd_parity_select_i,
    input wire logic parity_generate_enable_i,
    input wire logic fifo_reset_n_i,
    // Write side
    input wire logic write_side_clock_i,
    input wire logic write_strobe_n_i,
    input wire logic write_block_select_n_i,
    input wire logic async_write_strobe_i,
    input wire logic [ADDR_W-1:0] write_address_i,
    input wire logic [`PAR_BIT:0] write_data_in_i,
    // Read side
    input wire logic read_side_clock_i,
    input wire logic read_strobe_n_i,
    input wire logic read_block_select_n_i,
    input wire logic async_read_strobe_n_i,
    input wire logic [ADDR_W-1:0] read_address_i,
    output logic [`PAR_BIT:0] read_data_o,
    // Flags and errors
    output fifo_block_pkg::flags_t flags_o,
    output logic flags_valid_o,
    output logic read_parity_error_o,
    output logic write_parity_error_o,
    // Register port
    input wire logic [`REG_AW-1:0] reg_addr_i,
    input wire logic [`REG_DW-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [`REG_DW-1:0] reg_rdata_o,
    // Interrupt
    output logic irq_o
);

    localparam int CNT_W = ADDR_W + 1;
    localparam int DEPTH = 1 << ADDR_W;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection of side clocks

    logic wclk_q_r, wclk_q_nxt;
    logic rclk_q_r, rclk_q_nxt;
    logic awr_q_r, awr_q_nxt;
    logic wr_rise, rd_rise, rd_fall, awr_rise;

    always_comb begin
        wclk_q_nxt = write_side_clock_i;
        rclk_q_nxt = read_side_clock_i;
        awr_q_nxt = async_write_strobe_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wclk_q_r <= 1'b0;
            rclk_q_r <= 1'b0;
            awr_q_r <= 1'b0;
        end else if (ce_i) begin
            wclk_q_r <= wclk_q_nxt;
            rclk_q_r <= rclk_q_nxt;
            awr_q_r <= awr_q_nxt;
        end
    end

    assign wr_rise = write_side_clock_i & ~wclk_q_r; // R15
    assign rd_rise = read_side_clock_i & ~rclk_q_r; // R16
    assign rd_fall = ~read_side_clock_i & rclk_q_r; // R17
    assign awr_rise = async_write_strobe_i & ~awr_q_r;

    ////////////////////////////////////////////////////////////////////////////
    // Depth, pointers and occupancy

    fifo_block_pkg::mode_t mode;
    logic [CNT_W-1:0] depth;
    logic [ADDR_W-1:0] mask;
    logic [`DSEL_W:0] depth_exp;
    logic [ADDR_W-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic full_live, empty_live;
    logic sync_wr, sync_rd, wr_acc, rd_acc, async_rd;
    logic [ADDR_W-1:0] wr_idx, rd_idx;

    assign mode = fifo_block_pkg::mode_t'(fifo_mode_i);
    assign depth_exp = {1'b0, depth_log_select_i} + 1'b1; // R9
    assign depth = (int'(depth_exp) >= ADDR_W) ? CNT_W'(DEPTH) : (CNT_W'(1) << depth_exp); // R9
    assign mask = ADDR_W'(depth - 1'b1);
    assign full_live = (cnt_r == depth); // R18
    assign empty_live = (cnt_r == '0); // R18

    assign sync_wr = wr_rise & ~write_strobe_n_i & ~write_block_select_n_i; // R14
    assign sync_rd = rd_rise & ~read_strobe_n_i & ~read_block_select_n_i; // R14
    assign async_rd = (mode == fifo_block_pkg::MODE_RAM) & ~async_read_strobe_n_i;

    always_comb begin
        wr_acc = 1'b0;
        rd_acc = 1'b0;
        wr_idx = write_address_i;
        rd_idx = read_address_i;
        unique case (mode)
            fifo_block_pkg::MODE_FIFO: begin
                wr_acc = sync_wr & ~full_live; // R1
                rd_acc = sync_rd & ~empty_live; // R2
                wr_idx = wptr_r;
                rd_idx = rptr_r;
            end
            fifo_block_pkg::MODE_RAM: begin
                wr_acc = sync_wr | awr_rise; // R15
                rd_acc = sync_rd;
            end
        endcase
    end

    always_comb begin
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        cnt_nxt = cnt_r;
        if (!fifo_reset_n_i) begin
            wptr_nxt = '0; // R3
            rptr_nxt = '0; // R3
            cnt_nxt = '0; // R3
        end else if (mode == fifo_block_pkg::MODE_FIFO) begin
            if (wr_acc) begin
                wptr_nxt = (wptr_r + 1'b1) & mask; // R18
            end
            if (rd_acc) begin
                rptr_nxt = (rptr_r + 1'b1) & mask; // R18
            end
            cnt_nxt = cnt_r + CNT_W'(wr_acc) - CNT_W'(rd_acc);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else if (ce_i) begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity and storage

    logic gen_par, wr_chk_par, rd_chk_par;
    fifo_block_pkg::word_t wr_word, rd_word;
    logic [`PAR_BIT:0] mem_r [DEPTH];
    logic [`PAR_BIT:0] mem_nxt [DEPTH];

    parity_bit gen_u (
        .data_i(write_data_in_i[`PAR_BIT-1:0]),
        .odd_i(odd_parity_select_i),
        .par_o(gen_par)
    );

    // Write check shares the generator result, as both look at the same byte
    assign wr_chk_par = gen_par;
    assign wr_word.bits = write_data_in_i[`PAR_BIT-1:0];
    assign wr_word.par = parity_generate_enable_i ? gen_par : write_data_in_i[`PAR_BIT]; // R11

    always_comb begin
        mem_nxt = mem_r;
        if (wr_acc) begin
            mem_nxt[wr_idx] = wr_word;
        end
    end

    // Storage has no reset so a pointer reset leaves it intact
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            mem_r <= mem_nxt; // R3
        end
    end

    // Same-location write bypasses the array
    assign rd_word = (wr_acc && wr_idx == rd_idx) ? wr_word : mem_r[rd_idx]; // R5 R6

    parity_bit chk_u (
        .data_i(rd_word.bits),
        .odd_i(odd_parity_select_i),
        .par_o(rd_chk_par)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data and parity errors

    logic [`PAR_BIT:0] dout_r, dout_nxt;
    logic rpe_r, rpe_nxt, wpe_r, wpe_nxt;
    logic rpe_ev, wpe_ev;

    assign rpe_ev = (rd_acc | async_rd) & (rd_chk_par != rd_word.par);
    assign wpe_ev = wr_acc & ~parity_generate_enable_i & (wr_chk_par != write_data_in_i[`PAR_BIT]);

    always_comb begin
        dout_nxt = dout_r;
        rpe_nxt = rpe_r;
        wpe_nxt = wpe_r;
        if (!fifo_reset_n_i) begin
            dout_nxt = '0; // R3
            rpe_nxt = 1'b0;
        end else if (rd_acc || async_rd) begin
            dout_nxt = rd_word; // R16 R6
            rpe_nxt = rpe_ev; // R12
        end
        if (wr_acc) begin
            wpe_nxt = wpe_ev; // R12
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_r <= '0;
            rpe_r <= 1'b0;
            wpe_r <= 1'b0;
        end else if (ce_i) begin
            dout_r <= dout_nxt;
            rpe_r <= rpe_nxt;
            wpe_r <= wpe_nxt;
        end
    end

    assign read_data_o = dout_r;
    assign read_parity_error_o = rpe_r;
    assign write_parity_error_o = wpe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Flags, updated on the read clock fall

    logic [CNT_W-1:0] eq_target, ge_target;
    fifo_block_pkg::flags_t flg_r, flg_nxt;
    logic fvalid_r, fvalid_nxt;

    always_comb begin
        if (depth > CNT_W'(`LEVEL_SPAN)) begin
            ge_target = CNT_W'({level_i, 1'b0}); // R8
            eq_target = CNT_W'({level_i, 1'b0}) + 1'b1; // R8
        end else begin
            ge_target = CNT_W'(level_i);
            eq_target = CNT_W'(level_i);
        end
    end

    always_comb begin
        flg_nxt = flg_r;
        fvalid_nxt = fvalid_r;
        if (!fifo_reset_n_i) begin
            flg_nxt = '0;
            flg_nxt.empty = 1'b1; // R3
            fvalid_nxt = 1'b1;
        end else begin
            if (cnt_nxt != cnt_r) begin
                fvalid_nxt = 1'b0; // R17
            end
            if (rd_fall) begin
                flg_nxt.empty = empty_live; // R17
                flg_nxt.full = full_live;
                flg_nxt.level_equal_flag = (cnt_r == eq_target); // R7
                flg_nxt.level_at_least_flag = (cnt_r >= ge_target); // R7
                fvalid_nxt = (cnt_nxt == cnt_r);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flg_r <= '{empty: 1'b1, full: 1'b0, level_equal_flag: 1'b0, level_at_least_flag: 1'b0};
            fvalid_r <= 1'b1;
        end else if (ce_i) begin
            flg_r <= flg_nxt;
            fvalid_r <= fvalid_nxt;
        end
    end

    assign flags_o = flg_r;
    assign flags_valid_o = fvalid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register port and interrupt

    logic [`EV_W-1:0] ev, st_r, st_nxt, en_r, en_nxt, clr;
    logic [`REG_DW-1:0] rdata_r, rdata_nxt;

    always_comb begin
        ev = '0;
        ev[`EV_WR_FULL] = sync_wr & full_live & (mode == fifo_block_pkg::MODE_FIFO);
        ev[`EV_RD_EMPTY] = sync_rd & empty_live & (mode == fifo_block_pkg::MODE_FIFO);
        ev[`EV_RD_PARITY] = rpe_ev;
        ev[`EV_WR_PARITY] = wpe_ev;
        clr = (reg_write_i && reg_addr_i == `REG_INT_CLEAR) ? reg_wdata_i[`EV_W-1:0] : '0;
        // Set beats clear so no event is lost
        st_nxt = (st_r & ~clr) | ev;
        en_nxt = (reg_write_i && reg_addr_i == `REG_INT_ENABLE) ? reg_wdata_i[`EV_W-1:0] : en_r;
        rdata_nxt = '0;
        if (reg_read_i) begin
            unique case (reg_addr_i)
                `REG_STATUS: rdata_nxt = `REG_DW'(st_r);
                `REG_INT_ENABLE: rdata_nxt = `REG_DW'(en_r);
                `REG_OCCUPANCY: rdata_nxt = `REG_DW'(cnt_r);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= `EV_RESET;
            en_r <= `EV_RESET;
            rdata_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign irq_o = |(st_r & en_r);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    full_drop_a: assert property (ce_i && mode == fifo_block_pkg::MODE_FIFO && full_live && !rd_acc
        && fifo_reset_n_i |=> cnt_r == $past(cnt_r) && wptr_r == $past(wptr_r)) // R1
        else $error("write taken while full");
    empty_hold_a: assert property (ce_i && mode == fifo_block_pkg::MODE_FIFO && empty_live && fifo_reset_n_i
        |=> rptr_r == $past(rptr_r)) // R2
        else $error("read pointer moved while empty");
    ptr_reset_a: assert property (ce_i && !fifo_reset_n_i
        |=> cnt_r == '0 && wptr_r == '0 && read_data_o == '0 && flags_o.empty) // R3
        else $error("pointer reset incomplete");
    same_loc_a: assert property (ce_i && fifo_reset_n_i && rd_acc && wr_acc && wr_idx == rd_idx
        |=> read_data_o == $past(wr_word)) // R5
        else $error("same location read missed write data");
    async_fresh_a: assert property (ce_i && fifo_reset_n_i && async_rd && wr_acc && wr_idx == read_address_i
        |=> read_data_o == $past(wr_word)) // R6
        else $error("asynchronous read not refreshed");
    level_eq_a: assert property (ce_i && fifo_reset_n_i && rd_fall
        |=> flags_o.level_equal_flag == ($past(cnt_r) == $past(eq_target))
        && flags_o.level_at_least_flag == ($past(cnt_r) >= $past(ge_target))) // R7 R8
        else $error("level flags wrong after update");
    depth_bound_a: assert property (cnt_r <= depth || $changed(depth_log_select_i)) // R9
        else $error("occupancy beyond depth");
    par_gen_a: assert property (ce_i && wr_acc && parity_generate_enable_i
        |-> wr_word.par == ((^write_data_in_i[`PAR_BIT-1:0]) ^ odd_parity_select_i)) // R11 R10
        else $error("generated parity wrong");
    wpe_gen_a: assert property (ce_i && wr_acc && parity_generate_enable_i |=> !write_parity_error_o) // R12
        else $error("write parity error while generating");
    flag_fall_a: assert property (ce_i && !rd_fall && fifo_reset_n_i |=> flags_o == $past(flags_o)) // R17
        else $error("flags changed off the read clock fall");
    wrap_a: assert property (ce_i && fifo_reset_n_i && mode == fifo_block_pkg::MODE_FIFO && wr_acc
        && wptr_r == mask |=> wptr_r == '0) // R18
        else $error("write pointer did not wrap");
    pipe_read_a: assert property (ce_i && fifo_reset_n_i && rd_acc && !async_rd
        |=> read_data_o == $past(rd_word)) // R16
        else $error("pipelined read data wrong");

    fill_c: cover property (ce_i && wr_acc ##[1:600] full_live);
    drain_c: cover property (full_live ##[1:600] empty_live);
    bypass_c: cover property (ce_i && rd_acc && wr_acc && wr_idx == rd_idx);
    irq_c: cover property (irq_o ##[1:20] !irq_o);

endmodule

// ---- common/fifo_block_defines.svh ----
// Purpose: Named constants for the embedded RAM/FIFO block
// Assumes: Included by its bare name wherever the constants are used
// Notes: Register offsets and field positions live here only
`ifndef FIFO_BLOCK_DEFINES_SVH
`define FIFO_BLOCK_DEFINES_SVH

// Register port
`define REG_AW 4
`define REG_DW 16
`define REG_STATUS 4'h0
`define REG_INT_CLEAR 4'h1
`define REG_INT_ENABLE 4'h2
`define REG_OCCUPANCY 4'h3

// Status and enable bit positions
`define EV_W 4
`define EV_WR_FULL 0
`define EV_RD_EMPTY 1
`define EV_RD_PARITY 2
`define EV_WR_PARITY 3
`define EV_RESET 4'h0

// Data word layout and configuration input widths
`define PAR_BIT 8
`define LEVEL_W 8
`define DSEL_W 3

// Depth above which the level input is scaled by two
`define LEVEL_SPAN 256

`endif

// ---- common/fifo_block_pkg.sv ----
// Purpose: Types shared by the RAM/FIFO block
// Assumes: Nothing
// Notes: Constants are in fifo_block_defines.svh
package fifo_block_pkg;

    typedef enum logic {
        MODE_RAM,
        MODE_FIFO
    } mode_t;

    typedef struct packed {
        logic par;
        logic [7:0] bits;
    } word_t;

    typedef struct packed {
        logic empty;
        logic full;
        logic level_equal_flag;
        logic level_at_least_flag;
    } flags_t;

endpackage

// ---- logic/parity_bit.sv ----
// Purpose: Parity bit over one data byte
// Assumes: Combinational, no state
// Notes: Odd select high gives a bit that makes the nine-bit total odd
`timescale 1ns/1ps

module parity_bit (
    // Data
    input wire logic [7:0] data_i,
    // Sense
    input wire logic odd_i,
    // Result
    output logic par_o
);

    assign par_o = (^data_i) ^ odd_i; // R10

endmodule

// ---- tb/fifo_user_model.sv ----
// Purpose: User logic that drives the write and read ports of the block
// Assumes: Side clocks move only inside a transfer and stand still between them
// Notes: Once its hold has run out, the data line shows the inverted word
`timescale 1ns/1ps

module fifo_user_model (
    // Clock
    input wire logic clk_i,
    // Write side
    output logic wclk_o,
    output logic wstb_n_o,
    output logic wsel_n_o,
    output logic awstb_o,
    output logic [8:0] wdata_o,
    // Read side
    output logic rclk_o,
    output logic rstb_n_o,
    output logic rsel_n_o
);
    initial begin
        {wclk_o, awstb_o, rclk_o} = 3'h0;
        {wstb_n_o, wsel_n_o, rstb_n_o, rsel_n_o} = 4'hf;
        wdata_o = 9'h000;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write clock high for one cycle, strobes held across its rise
    task automatic put(input logic [8:0] d);
        @(posedge clk_i);
        wclk_o <= 1'b1;
        {wstb_n_o, wsel_n_o} <= 2'h0;
        wdata_o <= d;
        @(posedge clk_i);
        wclk_o <= 1'b0;
        {wstb_n_o, wsel_n_o} <= 2'h3;
        wdata_o <= ~d;
    endtask
    // Asynchronous write pulse
    task automatic aput(input logic [8:0] d);
        @(posedge clk_i);
        awstb_o <= 1'b1;
        wdata_o <= d;
        @(posedge clk_i);
        awstb_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // Read clock pulse; with go low it only moves the flags
    // Next strobe comes a full cycle later, past the unsure acceptance span
    task automatic get(input logic go);
        @(posedge clk_i);
        rclk_o <= 1'b1;
        {rstb_n_o, rsel_n_o} <= {~go, ~go};
        @(posedge clk_i);
        rclk_o <= 1'b0;
        {rstb_n_o, rsel_n_o} <= 2'h3;
        @(posedge clk_i);
    endtask
endmodule

// ---- tb/ram_fifo_block_test.sv ----
// Purpose: Self-checking bench for the RAM/FIFO block
// Assumes: FIFO depth four and level two in most FIFO tests; clock enable high outside its own test
// Notes: Flags are looked at after a read clock fall, a reset or a pointer reset
`timescale 1ns/1ps
`include "fifo_block_defines.svh"

module ram_fifo_block_test;
    logic clk, rst_b, ce, fmode, odd, pgen, frst_n, arstb_n;
    logic wclk, wstb_n, wsel_n, awstb, rclk, rstb_n, rsel_n;
    logic reg_write, reg_read, read_parity_error, write_parity_error, fvalid, irq;
    logic [2:0] dsel;
    logic [7:0] level;
    logic [8:0] write_address, read_address, wdata, rdata;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    fifo_block_pkg::flags_t flags;
    int fails = 0;
    int checked = 0;

    always #2 clk = ~clk;

    ram_fifo_block i_ram_fifo_block (
        .clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
        .fifo_mode_i(fmode), .depth_log_select_i(dsel), .level_i(level),
        .odd_parity_select_i(odd), .parity_generate_enable_i(pgen), .fifo_reset_n_i(frst_n),
        .write_side_clock_i(wclk), .write_strobe_n_i(wstb_n), .write_block_select_n_i(wsel_n),
        .async_write_strobe_i(awstb), .write_address_i(write_address), .write_data_in_i(wdata),
        .read_side_clock_i(rclk), .read_strobe_n_i(rstb_n), .read_block_select_n_i(rsel_n),
        .async_read_strobe_n_i(arstb_n), .read_address_i(read_address), .read_data_o(rdata),
        .flags_o(flags), .flags_valid_o(fvalid), .read_parity_error_o(read_parity_error),
        .write_parity_error_o(write_parity_error), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata), .irq_o(irq)
    );

    fifo_user_model i_fifo_user_model (
        .clk_i(clk), .wclk_o(wclk), .wstb_n_o(wstb_n), .wsel_n_o(wsel_n), .awstb_o(awstb),
        .wdata_o(wdata), .rclk_o(rclk), .rstb_n_o(rstb_n), .rsel_n_o(rsel_n)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Word with its own parity bit; odd high makes the nine-bit total odd
    function automatic logic [8:0] w(input logic [7:0] b, input logic o);
        return {^b ^ o, b};
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // Flags for n words held, level two, depth four
    task automatic fchk(input int n);
        #1 chk({fvalid, flags}, {1'b1, n == 0, n == 4, n == 2, n >= 2});
    endtask

    task automatic give_verdict();
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        {clk, rst_b, reg_write, reg_read, ce} = 5'h01;
        {fmode, odd, pgen, frst_n, arstb_n} = 5'h13;
        write_address = 9'h000;
        read_address = 9'h000;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        dsel = 3'h1;
        level = 8'h02;
        repeat (4) @(posedge clk);
        #1 chk({rdata, flags, fvalid, irq, read_parity_error, write_parity_error}, 17'h00088);
        @(posedge clk);
        rst_b <= 1'b1;
        wr(`REG_INT_ENABLE, 16'h000f);
        rchk(`REG_INT_ENABLE, 16'h000f);
        wr(`REG_STATUS, 16'h000f);
        rchk(`REG_STATUS, 16'h0000);
        rchk(4'hf, 16'h0000);
        for (int i = 1; i <= 4; i++) begin
            i_fifo_user_model.put(w(8'(i * 8'h11), 1'b0));
            #1 chk(fvalid, 1'b0);
            i_fifo_user_model.get(1'b0);
            fchk(i);
        end
        i_fifo_user_model.put(w(8'h99, 1'b0));
        rchk(`REG_STATUS, 16'h0001);
        chk(irq, 1'b1);
        rchk(`REG_OCCUPANCY, 16'h0004);
        wr(`REG_INT_CLEAR, 16'h0001);
        rchk(`REG_STATUS, 16'h0000);
        chk(irq, 1'b0);
        for (int i = 1; i <= 4; i++) begin
            i_fifo_user_model.get(1'b1);
            #1 chk(rdata, w(8'(i * 8'h11), 1'b0));
            fchk(4 - i);
        end
        i_fifo_user_model.get(1'b1);
        #1 chk(rdata, w(8'h44, 1'b0));
        rchk(`REG_STATUS, 16'h0002);
        wr(`REG_INT_ENABLE, 16'h000d);
        #1 chk(irq, 1'b0);
        wr(`REG_INT_ENABLE, 16'h000f);
        #1 chk(irq, 1'b1);
        wr(`REG_INT_CLEAR, 16'h0002);
        #1 chk(irq, 1'b0);
        // Pointers have wrapped; a stale read pointer would return old data
        i_fifo_user_model.put(w(8'h5a, 1'b0));
        i_fifo_user_model.get(1'b1);
        #1 chk(rdata, w(8'h5a, 1'b0));
        for (int o = 0; o < 2; o++) begin
            @(posedge clk);
            odd <= o[0];
            pgen <= 1'b1;
            i_fifo_user_model.put(w(8'h03, o[0]) ^ 9'h100);
            i_fifo_user_model.get(1'b1);
            #1 chk({rdata, read_parity_error, write_parity_error}, {w(8'h03, o[0]), 2'h0});
        end
        @(posedge clk);
        {odd, pgen} <= 2'h0;
        i_fifo_user_model.put(w(8'h07, 1'b0) ^ 9'h100);
        @(posedge clk);
        #1 chk(write_parity_error, 1'b1);
        i_fifo_user_model.get(1'b1);
        #1 chk({rdata, read_parity_error}, {w(8'h07, 1'b0) ^ 9'h100, 1'b1});
        rchk(`REG_STATUS, 16'h000c);
        chk(irq, 1'b1);
        wr(`REG_INT_CLEAR, 16'h000f);
        i_fifo_user_model.put(w(8'h21, 1'b0));
        i_fifo_user_model.put(w(8'h22, 1'b0));
        @(posedge clk);
        frst_n <= 1'b0;
        @(posedge clk);
        frst_n <= 1'b1;
        #1 chk({rdata, flags, read_parity_error}, {9'h000, 4'h8, 1'b0});
        rchk(`REG_OCCUPANCY, 16'h0000);
        // Frozen clock enable must swallow a whole write pulse
        @(posedge clk);
        ce <= 1'b0;
        i_fifo_user_model.put(w(8'h11, 1'b0));
        ce <= 1'b1;
        dsel <= 3'h0;
        level <= 8'h01;
        rchk(`REG_OCCUPANCY, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            i_fifo_user_model.put(w(8'(i), 1'b0));
        end
        i_fifo_user_model.get(1'b0);
        #1 chk({fvalid, flags}, 5'h15);
        rchk(`REG_OCCUPANCY, 16'h0002);
        @(posedge clk);
        fmode <= 1'b0;
        write_address <= 9'h005;
        read_address <= 9'h005;
        i_fifo_user_model.put(w(8'h3c, 1'b0));
        arstb_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(rdata, w(8'h3c, 1'b0));
        i_fifo_user_model.aput(w(8'hc3, 1'b0));
        repeat (2) @(posedge clk);
        #1 chk(rdata, w(8'hc3, 1'b0));
        @(posedge clk);
        frst_n <= 1'b0;
        @(posedge clk);
        frst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(rdata, w(8'hc3, 1'b0));
        @(posedge clk);
        arstb_n <= 1'b1;
        write_address <= 9'h007;
        read_address <= 9'h007;
        fork
            i_fifo_user_model.put(w(8'h6e, 1'b0));
            i_fifo_user_model.get(1'b1);
        join
        #1 chk(rdata, w(8'h6e, 1'b0));
        give_verdict();
    end
endmodule
